// >>> core/drpm_params.svh
// Register offsets, field positions, reset values and timing counts of the refresh/power block
`ifndef DRPM_PARAMS_SVH
`define DRPM_PARAMS_SVH

// Register byte offsets on the configuration bus
`define DRPM_OFS_SOFT_RESET    12'h000
`define DRPM_OFS_REFRESH_1     12'h004
`define DRPM_OFS_REFRESH_2     12'h008
`define DRPM_OFS_POWER_DOWN    12'h00C
`define DRPM_OFS_MODE          12'h010
`define DRPM_OFS_PD_TIMEOUT    12'h014

// Field positions
`define DRPM_SOFT_RSTN_BIT     0
`define DRPM_REF_UPD_BIT       6
`define DRPM_REFI_LSB          3
`define DRPM_REFI_MSB          14
`define DRPM_RBURST_MSB        2
`define DRPM_PD_EN_BIT         1
`define DRPM_DPD_EN_BIT        0
`define DRPM_DDR3_BIT          8
`define DRPM_MOBILE_BIT        7
`define DRPM_SDR_BIT           6
`define DRPM_TEST_BIT          5
`define DRPM_ECC_MSB           4
`define DRPM_ECC_LSB           2
`define DRPM_DQW_MSB           1
`define DRPM_PDTO_MSB          7

// Reset values
`define DRPM_REFI_RST          12'h052
`define DRPM_RBURST_RST        3'h0
`define DRPM_PD_EN_RST         1'b1
`define DRPM_PDTO_RST          8'h10

// Encodings
`define DRPM_ECC_OFF           3'h0
`define DRPM_ECC_SECDED        3'h5
`define DRPM_DQW_FULL          2'h0
`define DRPM_DQW_HALF          2'h1
`define DRPM_DQW_QUARTER       2'h2

// Timing: interval unit in clocks and refresh-to-refresh gap in clocks; cap on pending refreshes
`define DRPM_CLK_PER_UNIT      32
`define DRPM_T_RFC_CYC         8'h23
`define DRPM_PEND_MAX          4'h8

`endif

// >>> core/drpm_pkg.sv
// Types shared by the refresh/power block
package drpm_pkg;
    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_POWER_DOWN,
        PS_DEEP_SLEEP
    } drpm_pwr_e;
endpackage

// >>> core/drpm_refresh_sched.sv
// Refresh interval timer and pending-refresh counter
`timescale 1ns/1ps
`default_nettype none
`include "drpm_params.svh"
module drpm_refresh_sched (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        run,
    input  wire logic [11:0] interval,
    input  wire logic [2:0]  group_size,
    input  wire logic        issue,
    output logic      [3:0]  pending,
    output logic             limit_hit
);
    logic [4:0]  unit_r;
    logic [11:0] units_r;
    logic        tick;
    logic [3:0]  limit;

    // One tick per interval times 32 clocks; an interval of zero behaves as one
    assign tick = run && (unit_r == 5'(`DRPM_CLK_PER_UNIT - 1)) &&
                  (units_r + 12'h001 >= interval);

    // Prescaler and unit counter
    always_ff @(posedge core_clk) begin
        if (reset || !run) begin
            unit_r  <= 5'h00;
            units_r <= 12'h000;
        end else begin
            unit_r <= unit_r + 5'h01;
            if (unit_r == 5'(`DRPM_CLK_PER_UNIT - 1)) begin
                units_r <= tick ? 12'h000 : units_r + 12'h001;  // [R1] [R18]
            end
        end
    end

    // Add one per timeout up to 8, remove one per issued refresh
    always_ff @(posedge core_clk) begin
        if (reset || !run) begin
            pending <= 4'h0;
        end else if (tick && !issue && pending != `DRPM_PEND_MAX) begin
            pending <= pending + 4'h1;  // [R18]
        end else if (!tick && issue && pending != 4'h0) begin
            pending <= pending - 4'h1;  // [R18]
        end
    end

    // Allowed backlog is group size plus one
    assign limit     = {1'b0, group_size} + 4'h1;  // [R2]
    assign limit_hit = (pending >= limit);         // [R3]
endmodule
`default_nettype wire

// >>> core/drpm_ctrl.sv
// Refresh scheduling, power-down control and operating-mode registers of the DRAM controller
// Operation
// [R1] Refresh every interval field times 32 clocks
// [R2] Burst field plus one timeouts may accumulate
// [R3] Backlog at limit blocks traffic, forces refreshes
// [R4] Idle timeout enters power-down when enabled
// [R5] Power-down enable changeable anytime, honoured live
// [R6] Deep sleep entered when store empty, mobile
// [R7] Clearing deep enable exits deep sleep
// [R8] Bit 8 selects DDR3 or DDR2
// [R9] Bit 7 selects mobile memory device
// [R10] Bit 6 selects single data rate mode
// [R11] Bit 5 selects test mode
// [R12] ECC field: 000 off, 101 on
// [R13] Width field sets full, half, quarter lanes
// [R14] Half width needs 16-bit multiple bus
// [R15] Software preserves reserved bits, ignores reads
// [R16] Release soft reset after full programming
// [R17] Update toggle or reset exit loads refresh
// [R18] Counter adds timeouts, subtracts issued refreshes
`timescale 1ns/1ps
`default_nettype none
`include "drpm_params.svh"
module drpm_ctrl #(
    parameter bit MOBILE_SUPPORT = 1'b1,
    parameter bit SDR_SUPPORT    = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_req_valid,
    input  wire logic        txn_store_empty,
    output logic             host_block,
    output logic             refresh_issue,
    output logic             dram_cke,
    output logic             power_down_active,
    output logic             deep_sleep_active,
    output logic             ctrl_in_reset,
    output logic             dram_gen_select,
    output logic             low_power_dram_select,
    output logic             single_rate_select,
    output logic             controller_test_select,
    output logic             ecc_enable,
    output logic      [3:0]  dq_lane_enable
);
    // Configuration registers
    logic        controller_soft_reset_n_r;
    logic        refresh_update_toggle_r;
    logic [11:0] avg_refresh_interval_x32_r;
    logic [2:0]  refresh_group_size_r;
    logic        idle_sleep_enable_r;
    logic        deep_sleep_enable_r;
    logic [7:0]  idle_sleep_timeout_r;
    logic [8:0]  mode_r;

    // Working copies of the refresh settings and their load triggers
    logic [11:0] refi_act_r;
    logic [2:0]  burst_act_r;
    logic        toggle_seen_r;
    logic        soft_rstn_d_r;

    // Refresh and power state
    drpm_pkg::drpm_pwr_e pwr_r;
    drpm_pkg::drpm_pwr_e pwr_nxt;
    logic [7:0]  gap_r;
    logic        forced_r;
    logic [4:0]  idle_unit_r;
    logic [7:0]  idle_units_r;
    logic        idle_expired;
    logic        idle_now;
    logic [3:0]  pending;
    logic        limit_hit;
    logic        issue_go;
    logic        run;

    logic        wr_en;
    logic        rd_en;
    logic        addr_hit;

    // Register address decode
    function automatic logic decode_hit(input logic [11:0] a);
        decode_hit = (a == `DRPM_OFS_SOFT_RESET) || (a == `DRPM_OFS_REFRESH_1) ||
                     (a == `DRPM_OFS_REFRESH_2) || (a == `DRPM_OFS_POWER_DOWN) ||
                     (a == `DRPM_OFS_MODE) || (a == `DRPM_OFS_PD_TIMEOUT);
    endfunction

    assign addr_hit = decode_hit(paddr);
    assign wr_en    = psel && penable && pwrite && addr_hit;
    assign rd_en    = psel && !pwrite;  // Unmapped reads load zero
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_hit;

    // Register writes; reserved bits are not stored
    always_ff @(posedge core_clk) begin
        if (reset) begin
            controller_soft_reset_n_r  <= 1'b0;
            refresh_update_toggle_r    <= 1'b0;
            avg_refresh_interval_x32_r <= `DRPM_REFI_RST;       // [R1]
            refresh_group_size_r       <= `DRPM_RBURST_RST;
            idle_sleep_enable_r        <= `DRPM_PD_EN_RST;      // [R4]
            deep_sleep_enable_r        <= 1'b0;
            idle_sleep_timeout_r       <= `DRPM_PDTO_RST;
            mode_r                     <= 9'h000;               // [R8]
        end else if (wr_en) begin
            case (paddr)
                `DRPM_OFS_SOFT_RESET: begin
                    controller_soft_reset_n_r <= pwdata[`DRPM_SOFT_RSTN_BIT];
                end
                `DRPM_OFS_REFRESH_1: begin
                    refresh_update_toggle_r <= pwdata[`DRPM_REF_UPD_BIT];
                end
                `DRPM_OFS_REFRESH_2: begin
                    avg_refresh_interval_x32_r <= pwdata[`DRPM_REFI_MSB:`DRPM_REFI_LSB];
                    refresh_group_size_r       <= pwdata[`DRPM_RBURST_MSB:0];
                end
                `DRPM_OFS_POWER_DOWN: begin
                    idle_sleep_enable_r <= pwdata[`DRPM_PD_EN_BIT];   // [R5]
                    deep_sleep_enable_r <= MOBILE_SUPPORT && pwdata[`DRPM_DPD_EN_BIT];
                end
                `DRPM_OFS_MODE: begin
                    mode_r <= pwdata[`DRPM_DDR3_BIT:0];
                    if (!SDR_SUPPORT) begin
                        mode_r[`DRPM_SDR_BIT] <= 1'b0;  // [R10]
                    end
                end
                `DRPM_OFS_PD_TIMEOUT: begin
                    idle_sleep_timeout_r <= pwdata[`DRPM_PDTO_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data; reserved bits read as zero, live state in the soft reset and power-down words
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `DRPM_OFS_SOFT_RESET: prdata <= {27'h0000000, pending, controller_soft_reset_n_r};
                `DRPM_OFS_REFRESH_1:  prdata <= {25'h0000000, refresh_update_toggle_r, 6'h00};
                `DRPM_OFS_REFRESH_2:  prdata <= {17'h00000, avg_refresh_interval_x32_r,
                                                 refresh_group_size_r};
                `DRPM_OFS_POWER_DOWN: prdata <= {27'h0000000, deep_sleep_active, power_down_active,
                                                 forced_r, idle_sleep_enable_r,
                                                 deep_sleep_enable_r};
                `DRPM_OFS_MODE:       prdata <= {23'h000000, mode_r};
                `DRPM_OFS_PD_TIMEOUT: prdata <= {24'h000000, idle_sleep_timeout_r};
                default:              prdata <= 32'h00000000;
            endcase
        end
    end

    // Refresh settings are adopted on soft reset exit or on a toggle of the update bit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            soft_rstn_d_r <= 1'b0;
            toggle_seen_r <= 1'b0;
            refi_act_r    <= `DRPM_REFI_RST;
            burst_act_r   <= `DRPM_RBURST_RST;
        end else begin
            soft_rstn_d_r <= controller_soft_reset_n_r;
            toggle_seen_r <= refresh_update_toggle_r;
            if ((controller_soft_reset_n_r && !soft_rstn_d_r) ||
                (refresh_update_toggle_r != toggle_seen_r)) begin
                refi_act_r  <= avg_refresh_interval_x32_r;  // [R17]
                burst_act_r <= refresh_group_size_r;        // [R17]
            end
        end
    end

    // Refresh scheduling runs only while out of soft reset and not in deep sleep
    assign run = controller_soft_reset_n_r && (pwr_r != drpm_pkg::PS_DEEP_SLEEP);  // [R16]

    drpm_refresh_sched u_sched (
        .core_clk   (core_clk),
        .reset      (reset),
        .run        (run),
        .interval   (refi_act_r),
        .group_size (burst_act_r),
        .issue      (issue_go),
        .pending    (pending),
        .limit_hit  (limit_hit)
    );

    // Issue a refresh when idle or when the backlog forces it
    assign issue_go = run && (pwr_r == drpm_pkg::PS_ACTIVE) && (pending != 4'h0) &&
                      (pwr_nxt == drpm_pkg::PS_ACTIVE) && (gap_r == 8'h00) &&
                      (forced_r || (txn_store_empty && !host_req_valid));

    // Refresh-to-refresh spacing and issue pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            gap_r         <= 8'h00;
            refresh_issue <= 1'b0;
        end else begin
            refresh_issue <= issue_go;
            if (issue_go) begin
                gap_r <= `DRPM_T_RFC_CYC;
            end else if (gap_r != 8'h00) begin
                gap_r <= gap_r - 8'h01;
            end
        end
    end

    // Forced group: set at the limit, held until the backlog drains; set wins
    always_ff @(posedge core_clk) begin
        if (reset || !run) begin
            forced_r <= 1'b0;
        end else if (limit_hit) begin
            forced_r <= 1'b1;  // [R3]
        end else if (pending == 4'h0) begin
            forced_r <= 1'b0;
        end
    end

    // Held until the registered reset flag has dropped as well
    assign host_block = forced_r || limit_hit || !controller_soft_reset_n_r || ctrl_in_reset;  // [R3]

    // Idle timer in units of 32 clocks
    assign idle_now     = txn_store_empty && !host_req_valid && (pending == 4'h0) &&
                          controller_soft_reset_n_r;
    assign idle_expired = (idle_units_r >= idle_sleep_timeout_r);
    always_ff @(posedge core_clk) begin
        if (reset || !idle_now || pwr_r != drpm_pkg::PS_ACTIVE) begin
            idle_unit_r  <= 5'h00;
            idle_units_r <= 8'h00;
        end else begin
            idle_unit_r <= idle_unit_r + 5'h01;
            if (idle_unit_r == 5'(`DRPM_CLK_PER_UNIT - 1) && !idle_expired) begin
                idle_units_r <= idle_units_r + 8'h01;
            end
        end
    end

    // Power state transitions
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            drpm_pkg::PS_ACTIVE: begin
                if (deep_sleep_enable_r && txn_store_empty && controller_soft_reset_n_r) begin
                    pwr_nxt = drpm_pkg::PS_DEEP_SLEEP;  // [R6]
                end else if (idle_sleep_enable_r && idle_now && idle_expired) begin
                    pwr_nxt = drpm_pkg::PS_POWER_DOWN;  // [R4]
                end
            end
            drpm_pkg::PS_POWER_DOWN: begin
                if (!idle_sleep_enable_r || !idle_now || deep_sleep_enable_r) begin
                    pwr_nxt = drpm_pkg::PS_ACTIVE;  // [R5]
                end
            end
            drpm_pkg::PS_DEEP_SLEEP: begin
                if (!deep_sleep_enable_r) begin
                    pwr_nxt = drpm_pkg::PS_ACTIVE;  // [R7]
                end
            end
            default: pwr_nxt = drpm_pkg::PS_ACTIVE;
        endcase
    end

    // Power state register and clock-enable pin
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pwr_r             <= drpm_pkg::PS_ACTIVE;
            dram_cke          <= 1'b0;
            power_down_active <= 1'b0;
            deep_sleep_active <= 1'b0;
            ctrl_in_reset     <= 1'b1;
        end else begin
            pwr_r             <= pwr_nxt;
            dram_cke          <= controller_soft_reset_n_r && (pwr_nxt == drpm_pkg::PS_ACTIVE);
            power_down_active <= (pwr_nxt == drpm_pkg::PS_POWER_DOWN);
            deep_sleep_active <= (pwr_nxt == drpm_pkg::PS_DEEP_SLEEP);
            ctrl_in_reset     <= !controller_soft_reset_n_r;
        end
    end

    // Operating mode outputs, registered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dram_gen_select        <= 1'b0;
            low_power_dram_select  <= 1'b0;
            single_rate_select     <= 1'b0;
            controller_test_select <= 1'b0;
            ecc_enable             <= 1'b0;
            dq_lane_enable         <= 4'hF;
        end else begin
            dram_gen_select        <= mode_r[`DRPM_DDR3_BIT];    // [R8]
            low_power_dram_select  <= mode_r[`DRPM_MOBILE_BIT];  // [R9]
            single_rate_select     <= mode_r[`DRPM_SDR_BIT];     // [R10]
            controller_test_select <= mode_r[`DRPM_TEST_BIT];    // [R11]
            ecc_enable <= (mode_r[`DRPM_ECC_MSB:`DRPM_ECC_LSB] == `DRPM_ECC_SECDED);  // [R12]
            case (mode_r[`DRPM_DQW_MSB:0])
                `DRPM_DQW_FULL:    dq_lane_enable <= 4'hF;  // [R13]
                `DRPM_DQW_HALF:    dq_lane_enable <= 4'h3;  // [R13] [R14]
                `DRPM_DQW_QUARTER: dq_lane_enable <= 4'h1;  // [R13]
                default:           dq_lane_enable <= 4'hF;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> bench/drpm_dram_model.sv
// Behavioural DRAM seen through clock enable and refresh commands
`timescale 1ns/1ps
`default_nettype none
module drpm_dram_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        dram_cke,
    input  wire logic        refresh_issue,
    output logic      [15:0] ref_count,
    output logic             cke_viol
);
    // Counts refreshes; a refresh with the clock enable low is illegal
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ref_count <= 16'h0000;
            cke_viol  <= 1'b0;
        end else if (refresh_issue) begin
            ref_count <= ref_count + 16'h0001;
            cke_viol  <= cke_viol | !dram_cke;
        end
    end
endmodule
`default_nettype wire

// >>> bench/drpm_ctrl_chk.sv
// Concurrent checks on the refresh, power-down and mode ports
`timescale 1ns/1ps
`default_nettype none
`include "drpm_params.svh"
module drpm_ctrl_chk (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        host_block,
    input wire logic        refresh_issue,
    input wire logic        dram_cke,
    input wire logic        power_down_active,
    input wire logic        deep_sleep_active,
    input wire logic        ctrl_in_reset,
    input wire logic        dram_gen_select,
    input wire logic        ecc_enable,
    input wire logic [3:0]  dq_lane_enable
);
    logic [5:0]  gap_r;
    logic [31:0] mode_w_r;
    logic [3:0]  lane_exp;
    logic        wr_mode;
    logic        wr_pd;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Register writes in the access phase
    assign wr_mode = psel && penable && pwrite && (paddr == `DRPM_OFS_MODE);
    assign wr_pd   = psel && penable && pwrite && (paddr == `DRPM_OFS_POWER_DOWN);
    // Cycles since the last refresh, saturating
    always_ff @(posedge core_clk) begin
        if (reset) begin
            gap_r <= 6'h3F;
        end else if (refresh_issue) begin
            gap_r <= 6'h00;
        end else if (gap_r != 6'h3F) begin
            gap_r <= gap_r + 6'h01;
        end
    end
    // Last word written to the mode register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_w_r <= 32'h0000_0000;
        end else if (wr_mode) begin
            mode_w_r <= pwdata;
        end
    end
    // Lane enables expected from the width field
    always_comb begin
        case (mode_w_r[1:0])
            2'h1:    lane_exp = 4'h3;
            2'h2:    lane_exp = 4'h1;
            default: lane_exp = 4'hF;
        endcase
    end
    sequence deep_clear_s;
        wr_pd && !pwdata[`DRPM_DPD_EN_BIT] && deep_sleep_active;
    endsequence
    sequence pd_off_s;
        wr_pd && !pwdata[`DRPM_PD_EN_BIT] && power_down_active;
    endsequence
    a_refresh_single_pulse: assert property (refresh_issue |=> !refresh_issue)
        else $error("refresh pulse longer than one cycle");
    a_refresh_gap_kept: assert property (refresh_issue |-> gap_r >= 6'd35)
        else $error("refreshes too close together");
    a_no_refresh_asleep: assert property (refresh_issue |->
        !power_down_active && !deep_sleep_active)
        else $error("refresh while asleep");
    a_cke_low_asleep: assert property (power_down_active || deep_sleep_active |->
        !dram_cke)
        else $error("clock enable high while asleep");
    a_soft_reset_block: assert property (ctrl_in_reset |-> host_block && !dram_cke)
        else $error("traffic not blocked in soft reset");
    a_ecc_mode_decode: assert property (wr_mode |-> ##2
        ecc_enable == (mode_w_r[4:2] == 3'h5))
        else $error("ecc enable does not follow mode field");
    a_width_lane_decode: assert property (wr_mode |-> ##2 dq_lane_enable == lane_exp)
        else $error("lane enables do not follow width field");
    a_gen_select_decode: assert property (wr_mode |-> ##2 dram_gen_select == mode_w_r[8])
        else $error("dram generation select wrong");
    a_deep_exit_bound: assert property (deep_clear_s |-> ##[1:4] !deep_sleep_active)
        else $error("deep sleep not left");
    a_pd_enable_live: assert property (pd_off_s |-> ##[1:4] !power_down_active)
        else $error("power-down not left after disable");
endmodule
bind drpm_ctrl drpm_ctrl_chk u_drpm_ctrl_chk (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .host_block(host_block),
    .refresh_issue(refresh_issue), .dram_cke(dram_cke), .power_down_active(power_down_active),
    .deep_sleep_active(deep_sleep_active), .ctrl_in_reset(ctrl_in_reset),
    .dram_gen_select(dram_gen_select), .ecc_enable(ecc_enable), .dq_lane_enable(dq_lane_enable));
`default_nettype wire

// >>> bench/dram_refresh_power_mode_ctrl_test.sv
// Self-checking bench for the refresh, power-down and mode controller
`timescale 1ns/1ps
`default_nettype none
`include "drpm_params.svh"
module dram_refresh_power_mode_ctrl_test;
    logic core_clk, reset, psel, penable, pwrite, host_req_valid, txn_store_empty;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, host_block, refresh_issue, dram_cke, power_down_active;
    logic deep_sleep_active, ctrl_in_reset, gen, lp, sdr, tst, ecc, err, viol, tgl;
    logic [3:0] lanes;
    logic [15:0] refs;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    drpm_ctrl u_drpm_ctrl (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_req_valid(host_req_valid), .txn_store_empty(txn_store_empty),
        .host_block(host_block), .refresh_issue(refresh_issue), .dram_cke(dram_cke),
        .power_down_active(power_down_active), .deep_sleep_active(deep_sleep_active),
        .ctrl_in_reset(ctrl_in_reset), .dram_gen_select(gen), .low_power_dram_select(lp),
        .single_rate_select(sdr), .controller_test_select(tst), .ecc_enable(ecc),
        .dq_lane_enable(lanes));
    drpm_dram_model u_drpm_dram_model (.core_clk(core_clk), .reset(reset), .dram_cke(dram_cke),
        .refresh_issue(refresh_issue), .ref_count(refs), .cke_viol(viol));
    // Clock of 4 ns
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Setup then access phase; read data and error taken at the access edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        #1;
        psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(posedge core_clk);
        #1;
        penable = 1'b1;
        @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        #1;
        psel = 1'b0;
        penable = 1'b0;
    endtask
    // Bounded wait for a port to reach a level
    task automatic wait_lvl(input int sel, input logic lvl, input int limit);
        logic v;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            case (sel)
                0: v = refresh_issue;
                1: v = host_block;
                2: v = power_down_active;
                default: v = deep_sleep_active;
            endcase
        end while (v !== lvl && n < limit);
        if (v !== lvl) begin
            miscompares++;
            $display("[FAIL] wait %0d expected %b seen %b", sel, lvl, v);
            conclude();
        end
    endtask
    task automatic toggle_update();
        tgl = !tgl;
        apb(1'b1, `DRPM_OFS_REFRESH_1, {25'h0, tgl, 6'h0});
    endtask
    task automatic measure(input logic [31:0] exp);
        wait_lvl(0, 1'b1, 400);
        wait_lvl(0, 1'b0, 2);
        wait_lvl(0, 1'b1, 400);
        check32("refresh period", exp, n + 1);
    endtask
    task automatic t_reset_values();
        logic [11:0] ad [6] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h020};
        logic [31:0] ex [6] = '{32'h0, 32'h290, 32'h2, 32'h0, 32'h10, 32'h0};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ad[i], 32'h0);
            check32("reset readback", ex[i], rd);
            check32("slave error", {31'h0, i == 5}, {31'h0, err});
        end
        check32("cke in soft reset", 32'h0, {31'h0, dram_cke});
        check32("bus ready", 32'h1, {31'h0, pready});
    endtask
    task automatic t_mode();
        logic [31:0] md [10] = '{32'h100, 32'h080, 32'h040, 32'h020, 32'h014, 32'h015,
                                 32'h001, 32'h002, 32'h003, 32'h000};
        logic [8:0]  mx [10] = '{9'h10F, 9'h08F, 9'h04F, 9'h02F, 9'h01F, 9'h013,
                                 9'h003, 9'h001, 9'h00F, 9'h00F};
        // Attached data bus is 32 bits wide, so half width is legal
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, `DRPM_OFS_MODE, md[i]);
            apb(1'b0, `DRPM_OFS_MODE, 32'h0);
            check32("mode readback", md[i], rd);
            check32("mode outputs", {23'h0, mx[i]}, {23'h0, gen, lp, sdr, tst, ecc, lanes});
        end
    endtask
    task automatic t_refresh();
        apb(1'b1, `DRPM_OFS_REFRESH_2, 32'h10);
        apb(1'b1, `DRPM_OFS_SOFT_RESET, 32'h1);
        @(posedge core_clk);
        #1;
        check32("soft reset left", 32'h0, {31'h0, ctrl_in_reset});
        measure(32'd64);
        apb(1'b1, `DRPM_OFS_REFRESH_2, 32'h18);
        measure(32'd64);
        toggle_update();
        measure(32'd96);
        measure(32'd96);
    endtask
    task automatic t_burst(input logic [2:0] g);
        int cnt;
        apb(1'b1, `DRPM_OFS_REFRESH_2, {24'h0, 5'h10, g});
        toggle_update();
        host_req_valid = 1'b1;
        txn_store_empty = 1'b0;
        wait_lvl(1, 1'b1, (g + 2) * 512 + 100);
        cnt = 0;
        for (int k = 0; k < 400 && (host_block || k < 3); k++) begin
            @(posedge core_clk);
            #1;
            cnt += refresh_issue;
        end
        check32("group size", g + 1, cnt);
        host_req_valid = 1'b0;
        txn_store_empty = 1'b1;
    endtask
    task automatic t_power();
        apb(1'b1, `DRPM_OFS_PD_TIMEOUT, 32'h1);
        wait_lvl(2, 1'b1, 700);
        check32("cke in power-down", 32'h0, {31'h0, dram_cke});
        apb(1'b0, `DRPM_OFS_POWER_DOWN, 32'h0);
        apb(1'b1, `DRPM_OFS_POWER_DOWN, rd & ~32'h2);
        wait_lvl(2, 1'b0, 8);
        repeat (100) @(posedge core_clk);
        check32("power-down disabled", 32'h0, {31'h0, power_down_active});
        apb(1'b1, `DRPM_OFS_POWER_DOWN, 32'h2);
        wait_lvl(2, 1'b1, 700);
        apb(1'b1, `DRPM_OFS_POWER_DOWN, 32'h3);
        wait_lvl(3, 1'b1, 8);
        check32("cke in deep sleep", 32'h0, {31'h0, dram_cke});
        apb(1'b1, `DRPM_OFS_POWER_DOWN, 32'h2);
        wait_lvl(3, 1'b0, 8);
        check32("cke after deep exit", 32'h1, {31'h0, dram_cke});
    endtask
    // Main sequence
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, tgl} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        host_req_valid = 1'b0;
        txn_store_empty = 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        reset = 1'b0;
        t_reset_values();
        t_mode();
        t_refresh();
        t_burst(3'h0);
        t_burst(3'h1);
        t_burst(3'h7);
        t_power();
        check32("refresh while asleep", 32'h0, {31'h0, viol});
        conclude();
    end
endmodule
`default_nettype wire
